// ### pkg/codec_mode_pkg.sv
// Package: register map, field layout, reset values and step timing for the codec mode block
package codec_mode_pkg;

	// Register addresses on the control port
	localparam logic [7:0] ADDR_DAC_OUTPUT_CONTROL = 8'h44;
	localparam logic [7:0] ADDR_DAC_FILTER_FLAG_CONTROL = 8'h45;
	localparam logic [7:0] ADDR_ADC_LEFT_GAIN = 8'h46;
	localparam logic [7:0] ADDR_ADC_RIGHT_GAIN = 8'h47;
	localparam logic [7:0] ADDR_ADC_PORT_CONFIG = 8'h48;

	// Reset values
	localparam logic [7:0] RST_DAC_OUTPUT_CONTROL = 8'h00;
	localparam logic [7:0] RST_DAC_FILTER_FLAG_CONTROL = 8'h00;
	localparam logic [7:0] RST_ADC_GAIN = 8'hd7;
	localparam logic [7:0] RST_ADC_PORT_CONFIG = 8'h00;

	// Writable bits, reserved bits store and read zero
	localparam logic [7:0] MASK_DAC_OUTPUT_CONTROL = 8'h47;
	localparam logic [7:0] MASK_DAC_FILTER_FLAG_CONTROL = 8'hf3;
	localparam logic [7:0] MASK_ADC_PORT_CONFIG = 8'hf3;

	// Field positions, dac_output_control
	localparam int POS_DAC_OVERSAMPLE_DOUBLE = 6;
	localparam int POS_DAC_PHASE_INVERT = 2;
	localparam int POS_DAC_SOFT_MUTE_RIGHT = 1;
	localparam int POS_DAC_SOFT_MUTE_LEFT = 0;
	// Field positions, dac_filter_flag_control
	localparam int POS_DAC_ROLLOFF_SEL = 7;
	localparam int POS_DEEMPH_RATE_LSB = 5;
	localparam int POS_DEEMPH_ENABLE = 4;
	localparam int POS_SILENCE_FLAG_POLARITY = 1;
	localparam int POS_SILENCE_FLAG_COMBINE = 0;
	// Field positions, adc_port_config
	localparam int POS_ADC_CLOCK_SET_SEL = 7;
	localparam int POS_ADC_ROLE_LSB = 4;
	localparam int POS_ADC_WORD_FORMAT_LSB = 0;

	// Attenuator codes
	localparam logic [7:0] ADC_GAIN_UNITY = 8'hd7;
	localparam logic [7:0] ADC_MUTE_TOP = 8'h0e;
	localparam logic [7:0] DAC_MUTE_LEVEL = 8'h36;

	// Step timing, in sample periods
	localparam logic [9:0] DAC_STEP_FS = 10'h008;
	localparam logic [9:0] ADC_FIXED_STEP_FS = 10'h008;
	localparam logic [9:0] ZC_TIMEOUT_FS = 10'h200;

	// Bit clock runs at 64 fs
	localparam logic [10:0] BITCLK_PER_FRAME = 11'h040;

	// Serial word formats
	typedef enum logic [1:0] {
		FMT_I2S_24 = 2'h0,
		FMT_LEFT_24 = 2'h1,
		FMT_RIGHT_24 = 2'h2,
		FMT_RIGHT_16 = 2'h3
	} word_format_e;

	// Port roles
	typedef enum logic [2:0] {
		ROLE_SLAVE = 3'h0,
		ROLE_M768 = 3'h1,
		ROLE_M512 = 3'h2,
		ROLE_M384 = 3'h3,
		ROLE_M256 = 3'h4
	} adc_role_e;

	// One register access from the serial control decoder
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} ctrl_access_s;

	// DAC digital path settings
	typedef struct packed {
		logic oversample_double;
		logic [7:0] oversample_ratio;
		logic phase_invert;
		logic rolloff_sel;
		logic deemph_enable;
		logic [1:0] deemph_rate_sel;
	} dac_mode_s;

	// ADC port settings
	typedef struct packed {
		logic clock_set_sel;
		logic [2:0] role;
		logic [1:0] word_format;
	} adc_mode_s;

endpackage

// ### design/codec_digital_mode_control.sv
// Module: mode registers, DAC soft mute, ADC gain ramps, flags and ADC port clocking
`timescale 1ns/1ps
module codec_digital_mode_control
	import codec_mode_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire ctrl_access_s access,
	output logic rd_valid,
	output logic [7:0] rd_data,
	input wire logic fs_tick,
	input wire logic [1:0] dac_sysclk_ratio,
	input wire logic [7:0] dac_atten_left,
	input wire logic [7:0] dac_atten_right,
	input wire logic [1:0] dac_zero_detect,
	input wire logic [1:0] adc_zero_cross,
	input wire logic zc_detect_disable,
	input wire logic sysclk_a,
	input wire logic sysclk_b,
	input wire logic bitclk_a,
	input wire logic bitclk_b,
	input wire logic frameclk_a,
	input wire logic frameclk_b,
	output dac_mode_s dac_mode,
	output adc_mode_s adc_mode,
	output logic [7:0] dac_level_left,
	output logic [7:0] dac_level_right,
	output logic [7:0] adc_gain_level_left,
	output logic [7:0] adc_gain_level_right,
	output logic [1:0] adc_ramp_busy,
	output logic left_silence_flag,
	output logic right_silence_flag,
	output logic adc_bitclk_out,
	output logic adc_frameclk_out,
	output logic bitclk_a_oe_n,
	output logic frameclk_a_oe_n,
	output logic bitclk_b_oe_n,
	output logic frameclk_b_oe_n
);

	// One step of an attenuator toward its target
	function automatic logic [7:0] step_toward(input logic [7:0] cur, input logic [7:0] tgt);
		if (cur < tgt) begin
			step_toward = cur + 8'h01;
		end else if (cur > tgt) begin
			step_toward = cur - 8'h01;
		end else begin
			step_toward = cur;
		end
	endfunction

	// Sysclk cycles per frame for a master role, zero for slave
	function automatic logic [10:0] frame_ratio(input logic [2:0] role);
		case (role)
			ROLE_M768: frame_ratio = 11'h300;
			ROLE_M512: frame_ratio = 11'h200;
			ROLE_M384: frame_ratio = 11'h180;
			ROLE_M256: frame_ratio = 11'h100;
			default: frame_ratio = 11'h000;
		endcase
	endfunction

	// Oversampling factor from clock ratio group and double bit
	function automatic logic [7:0] osr_factor(input logic [1:0] ratio, input logic dbl);
		logic [7:0] base;
		base = 8'h10;
		case (ratio)
			2'h0: base = 8'h40;
			2'h1: base = 8'h20;
			default: base = 8'h10;
		endcase
		osr_factor = dbl ? {base[6:0], 1'b0} : base;
	endfunction

	logic [7:0] dac_output_control; // Register 0x44
	logic [7:0] dac_filter_flag_control; // Register 0x45
	logic [7:0] adc_gain_reg [2]; // Registers 0x46, 0x47
	logic [7:0] adc_port_config; // Register 0x48
	logic [7:0] dac_level [2]; // Current DAC attenuator
	logic [2:0] dac_div; // Sample periods toward next DAC step
	logic [7:0] adc_level [2]; // Current ADC gain
	logic [7:0] adc_target [2]; // Gain being ramped toward
	logic [7:0] adc_pend [2]; // Single-entry command buffer
	logic [1:0] adc_pend_v; // Buffer holds a command
	logic [8:0] zc_wait [2]; // Sample periods without zero cross
	logic [1:0] zc_timeout; // Timeout stepping active
	logic [2:0] fix_div [2]; // Fixed-interval step divider
	logic [1:0] adc_step; // Step strobe per channel
	logic [1:0] adc_busy; // Ramp in progress per channel
	logic [1:0] gain_wr; // Gain write per channel
	logic [5:0] pin_s1; // Pin synchroniser, first stage
	logic [5:0] pin_s2; // Second stage
	logic [5:0] pin_s3; // Third stage
	logic [5:0] pin_val; // Accepted pin levels
	logic sck_rise; // Accepted rising edge of selected sysclk
	logic [10:0] ratio; // Sysclk cycles per frame
	logic [9:0] frame_cnt; // Sysclk count in frame half
	logic [3:0] bit_cnt; // Sysclk count in bit clock half
	logic dac_step; // DAC ramp strobe

	assign gain_wr[0] = wr_en && access.addr == ADDR_ADC_LEFT_GAIN;
	assign gain_wr[1] = wr_en && access.addr == ADDR_ADC_RIGHT_GAIN;

	// Register writes, reserved bits forced to zero
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dac_output_control <= RST_DAC_OUTPUT_CONTROL;
			dac_filter_flag_control <= RST_DAC_FILTER_FLAG_CONTROL;
			adc_gain_reg[0] <= RST_ADC_GAIN;
			adc_gain_reg[1] <= RST_ADC_GAIN;
			adc_port_config <= RST_ADC_PORT_CONFIG;
		end else if (ce && wr_en) begin
			case (access.addr)
				ADDR_DAC_OUTPUT_CONTROL: begin
					dac_output_control <= access.data & MASK_DAC_OUTPUT_CONTROL;
				end
				ADDR_DAC_FILTER_FLAG_CONTROL: begin
					dac_filter_flag_control <= access.data & MASK_DAC_FILTER_FLAG_CONTROL;
				end
				ADDR_ADC_LEFT_GAIN: adc_gain_reg[0] <= access.data;
				ADDR_ADC_RIGHT_GAIN: adc_gain_reg[1] <= access.data;
				ADDR_ADC_PORT_CONFIG: begin
					adc_port_config <= access.data & MASK_ADC_PORT_CONFIG;
				end
				default: begin
					// Unmapped address, write ignored
				end
			endcase
		end
	end

	// Register reads, answer one cycle later
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rd_valid <= 1'b0;
			rd_data <= 8'h00;
		end else if (ce) begin
			rd_valid <= rd_en;
			if (rd_en) begin
				case (access.addr)
					ADDR_DAC_OUTPUT_CONTROL: rd_data <= dac_output_control;
					ADDR_DAC_FILTER_FLAG_CONTROL: rd_data <= dac_filter_flag_control;
					ADDR_ADC_LEFT_GAIN: rd_data <= adc_gain_reg[0];
					ADDR_ADC_RIGHT_GAIN: rd_data <= adc_gain_reg[1];
					ADDR_ADC_PORT_CONFIG: rd_data <= adc_port_config;
					default: rd_data <= 8'h00;
				endcase
			end
		end
	end

	// DAC and ADC mode outputs
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dac_mode <= '0;
			adc_mode <= '0;
		end else if (ce) begin
			dac_mode.oversample_double <= dac_output_control[POS_DAC_OVERSAMPLE_DOUBLE];
			dac_mode.oversample_ratio <= osr_factor(dac_sysclk_ratio,
				dac_output_control[POS_DAC_OVERSAMPLE_DOUBLE]);
			dac_mode.phase_invert <= dac_output_control[POS_DAC_PHASE_INVERT];
			dac_mode.rolloff_sel <= dac_filter_flag_control[POS_DAC_ROLLOFF_SEL];
			dac_mode.deemph_enable <= dac_filter_flag_control[POS_DEEMPH_ENABLE];
			dac_mode.deemph_rate_sel <=
				dac_filter_flag_control[POS_DEEMPH_RATE_LSB +: 2];
			adc_mode.clock_set_sel <= adc_port_config[POS_ADC_CLOCK_SET_SEL];
			adc_mode.role <= adc_port_config[POS_ADC_ROLE_LSB +: 3];
			adc_mode.word_format <= adc_port_config[POS_ADC_WORD_FORMAT_LSB +: 2];
		end
	end

	// Silence flags, combine then polarity
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			left_silence_flag <= 1'b0;
			right_silence_flag <= 1'b0;
		end else if (ce) begin
			if (dac_filter_flag_control[POS_SILENCE_FLAG_COMBINE]) begin
				left_silence_flag <= (&dac_zero_detect) ^
					dac_filter_flag_control[POS_SILENCE_FLAG_POLARITY];
				right_silence_flag <= (&dac_zero_detect) ^
					dac_filter_flag_control[POS_SILENCE_FLAG_POLARITY];
			end else begin
				left_silence_flag <= dac_zero_detect[0] ^
					dac_filter_flag_control[POS_SILENCE_FLAG_POLARITY];
				right_silence_flag <= dac_zero_detect[1] ^
					dac_filter_flag_control[POS_SILENCE_FLAG_POLARITY];
			end
		end
	end

	// DAC soft mute step divider
	assign dac_step = fs_tick && dac_div == 3'(DAC_STEP_FS - 10'h001);
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dac_div <= 3'h0;
		end else if (ce && fs_tick) begin
			dac_div <= dac_div + 3'h1;
		end
	end

	// DAC attenuators ramp toward mute or programmed level
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dac_level[0] <= DAC_MUTE_LEVEL;
			dac_level[1] <= DAC_MUTE_LEVEL;
		end else if (ce && dac_step) begin
			dac_level[0] <= step_toward(dac_level[0],
				dac_output_control[POS_DAC_SOFT_MUTE_LEFT] ? DAC_MUTE_LEVEL : dac_atten_left);
			dac_level[1] <= step_toward(dac_level[1],
				dac_output_control[POS_DAC_SOFT_MUTE_RIGHT] ? DAC_MUTE_LEVEL : dac_atten_right);
		end
	end

	// Per-channel ADC gain ramp
	for (genvar ch = 0; ch < 2; ch++) begin : g_adc
		assign adc_busy[ch] = adc_level[ch] != adc_target[ch];

		// Step strobe, zero cross or fixed interval
		always_comb begin
			if (zc_detect_disable) begin
				adc_step[ch] = fs_tick && fix_div[ch] == 3'(ADC_FIXED_STEP_FS - 10'h001);
			end else begin
				adc_step[ch] = fs_tick && (adc_zero_cross[ch] || zc_timeout[ch]);
			end
		end

		// Zero cross timeout and fixed divider
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				zc_wait[ch] <= 9'h000;
				zc_timeout[ch] <= 1'b0;
				fix_div[ch] <= 3'h0;
			end else if (ce && fs_tick) begin
				fix_div[ch] <= fix_div[ch] + 3'h1;
				if (adc_zero_cross[ch]) begin
					zc_wait[ch] <= 9'h000;
					zc_timeout[ch] <= 1'b0;
				end else if (zc_wait[ch] == 9'(ZC_TIMEOUT_FS - 10'h001)) begin
					zc_timeout[ch] <= 1'b1;
				end else begin
					zc_wait[ch] <= zc_wait[ch] + 9'h001;
				end
			end
		end

		// Target and single-entry command buffer
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				adc_target[ch] <= RST_ADC_GAIN;
				adc_pend[ch] <= RST_ADC_GAIN;
				adc_pend_v[ch] <= 1'b0;
			end else if (ce) begin
				if (gain_wr[ch] && adc_busy[ch]) begin
					adc_pend[ch] <= access.data;
					adc_pend_v[ch] <= 1'b1;
				end else if (gain_wr[ch]) begin
					adc_target[ch] <= access.data;
					adc_pend_v[ch] <= 1'b0;
				end else if (!adc_busy[ch] && adc_pend_v[ch]) begin
					adc_target[ch] <= adc_pend[ch];
					adc_pend_v[ch] <= 1'b0;
				end
			end
		end

		// Current gain, one half-dB code per step
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				adc_level[ch] <= RST_ADC_GAIN;
			end else if (ce && adc_step[ch]) begin
				adc_level[ch] <= step_toward(adc_level[ch], adc_target[ch]);
			end
		end
	end

	// Attenuator outputs
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dac_level_left <= DAC_MUTE_LEVEL;
			dac_level_right <= DAC_MUTE_LEVEL;
			adc_gain_level_left <= RST_ADC_GAIN;
			adc_gain_level_right <= RST_ADC_GAIN;
			adc_ramp_busy <= 2'h0;
		end else if (ce) begin
			dac_level_left <= dac_level[0];
			dac_level_right <= dac_level[1];
			adc_gain_level_left <= adc_level[0];
			adc_gain_level_right <= adc_level[1];
			adc_ramp_busy <= adc_busy | adc_pend_v;
		end
	end

	// Pin synchronisers, change accepted when stages two and three agree
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pin_s1 <= 6'h00;
			pin_s2 <= 6'h00;
			pin_s3 <= 6'h00;
			pin_val <= 6'h00;
		end else if (ce) begin
			pin_s1 <= {frameclk_b, frameclk_a, bitclk_b, bitclk_a, sysclk_b, sysclk_a};
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			for (int i = 0; i < 6; i++) begin
				if (pin_s2[i] == pin_s3[i]) begin
					pin_val[i] <= pin_s3[i];
				end
			end
		end
	end

	assign sck_rise = adc_port_config[POS_ADC_CLOCK_SET_SEL] ?
		(pin_s2[1] && pin_s3[1] && !pin_val[1]) :
		(pin_s2[0] && pin_s3[0] && !pin_val[0]);
	assign ratio = frame_ratio(adc_port_config[POS_ADC_ROLE_LSB +: 3]);

	// ADC port clocks, divided in master role, relayed in slave role
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			frame_cnt <= 10'h000;
			bit_cnt <= 4'h0;
			adc_bitclk_out <= 1'b0;
			adc_frameclk_out <= 1'b0;
		end else if (ce) begin
			if (ratio == 11'h000) begin
				frame_cnt <= 10'h000;
				bit_cnt <= 4'h0;
				adc_bitclk_out <= adc_port_config[POS_ADC_CLOCK_SET_SEL] ?
					pin_val[3] : pin_val[2];
				adc_frameclk_out <= adc_port_config[POS_ADC_CLOCK_SET_SEL] ?
					pin_val[5] : pin_val[4];
			end else if (sck_rise) begin
				if (bit_cnt == 4'(ratio / (BITCLK_PER_FRAME * 11'h002) - 11'h001)) begin
					bit_cnt <= 4'h0;
					adc_bitclk_out <= !adc_bitclk_out;
				end else begin
					bit_cnt <= bit_cnt + 4'h1;
				end
				if (frame_cnt == 10'(ratio / 11'h002 - 11'h001)) begin
					frame_cnt <= 10'h000;
					adc_frameclk_out <= !adc_frameclk_out;
				end else begin
					frame_cnt <= frame_cnt + 10'h001;
				end
			end
		end
	end

	// Drive enables, low on the selected set in a master role
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bitclk_a_oe_n <= 1'b1;
			frameclk_a_oe_n <= 1'b1;
			bitclk_b_oe_n <= 1'b1;
			frameclk_b_oe_n <= 1'b1;
		end else if (ce) begin
			bitclk_a_oe_n <= !(ratio != 11'h000 && !adc_port_config[POS_ADC_CLOCK_SET_SEL]);
			frameclk_a_oe_n <= !(ratio != 11'h000 && !adc_port_config[POS_ADC_CLOCK_SET_SEL]);
			bitclk_b_oe_n <= !(ratio != 11'h000 && adc_port_config[POS_ADC_CLOCK_SET_SEL]);
			frameclk_b_oe_n <= !(ratio != 11'h000 && adc_port_config[POS_ADC_CLOCK_SET_SEL]);
		end
	end

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	property p_phase;
		ce && !$past(sys_rst) |=> dac_mode.phase_invert == $past(dac_output_control[2]);
	endproperty
	a_phase: assert property (p_phase) else $error("phase invert mismatch");

	property p_dac_rate;
		ce && !dac_step |=> !ce || dac_level[0] == $past(dac_level[0]);
	endproperty
	a_dac_rate: assert property (p_dac_rate) else $error("DAC level moved off step");

	property p_dac_dir;
		ce && dac_step && dac_output_control[0] && dac_level[0] > DAC_MUTE_LEVEL
			|=> dac_level[0] == $past(dac_level[0]) - 8'h01;
	endproperty
	a_dac_dir: assert property (p_dac_dir) else $error("mute ramp not down");

	property p_dac_up;
		ce && dac_step && !dac_output_control[0] && dac_level[0] < dac_atten_left
			|=> dac_level[0] == $past(dac_level[0]) + 8'h01;
	endproperty
	a_dac_up: assert property (p_dac_up) else $error("unmute ramp not up");

	property p_flag;
		ce && dac_filter_flag_control[1:0] == 2'h0 && !sys_rst
			|=> !ce || left_silence_flag == $past(dac_zero_detect[0]);
	endproperty
	a_flag: assert property (p_flag) else $error("left flag wrong");

	property p_combine;
		ce && dac_filter_flag_control[1:0] == 2'h1
			|=> !ce || right_silence_flag == $past(&dac_zero_detect);
	endproperty
	a_combine: assert property (p_combine) else $error("combined flag wrong");

	property p_buffer;
		ce && gain_wr[0] && adc_busy[0] |=> adc_pend_v[0] && adc_pend[0] == $past(access.data);
	endproperty
	a_buffer: assert property (p_buffer) else $error("busy write not buffered");

	property p_hold_target;
		ce && gain_wr[0] && adc_busy[0] |=> adc_target[0] == $past(adc_target[0]);
	endproperty
	a_hold_target: assert property (p_hold_target) else $error("target moved mid ramp");

	property p_launch;
		ce && !adc_busy[0] && adc_pend_v[0] && !gain_wr[0]
			|=> adc_target[0] == $past(adc_pend[0]) && !adc_pend_v[0];
	endproperty
	a_launch: assert property (p_launch) else $error("buffered command lost");

	property p_fixed;
		ce && zc_detect_disable && fs_tick && fix_div[0] != 3'h7
			|=> adc_level[0] == $past(adc_level[0]);
	endproperty
	a_fixed: assert property (p_fixed) else $error("fixed step off interval");

	property p_timeout;
		ce && fs_tick && !zc_detect_disable && zc_timeout[0] && adc_busy[0]
			|=> adc_level[0] != $past(adc_level[0]);
	endproperty
	a_timeout: assert property (p_timeout) else $error("timeout step missing");

	property p_master_oe;
		ce && ratio != 11'h000 && !adc_port_config[7] ##1 ce |-> !bitclk_a_oe_n;
	endproperty
	a_master_oe: assert property (p_master_oe) else $error("master not driving");

	c_mute: cover property (ce && dac_output_control[0] && dac_level[0] == DAC_MUTE_LEVEL);
	c_buffered: cover property (adc_pend_v[0] ##1 !adc_pend_v[0]);
	c_timeout: cover property (zc_timeout[1] && adc_step[1]);
	c_master: cover property (adc_frameclk_out ##1 !adc_frameclk_out);

endmodule

// ### bench/codec_host_model.sv
// Host model: serial control writer and reader for the mode registers
`timescale 1ns/1ps
module codec_host_model
	import codec_mode_pkg::*;
(
	input wire logic clk,
	output logic wr_en,
	output logic rd_en,
	output ctrl_access_s access,
	input wire logic rd_valid,
	input wire logic [7:0] rd_data
);
	// Idle port at time zero
	initial begin
		wr_en = 1'b0;
		rd_en = 1'b0;
		access = 16'h0000;
	end
	// One write; strobe held one cycle, then the address and data are driven inverted
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		wr_en = 1'b1;
		access = {a, d};
		@(negedge clk);
		wr_en = 1'b0;
		access = ~{a, d};
	endtask
	// One read; data taken while the valid pulse stands
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		rd_en = 1'b1;
		access = {a, 8'h00};
		@(negedge clk);
		rd_en = 1'b0;
		access = ~{a, 8'h00};
		d = rd_valid ? rd_data : 8'hxx;
	endtask
endmodule

// ### bench/test_codec_digital_mode_control.sv
// Testbench: registers, mode decode, flags, ramps and port clocks
`timescale 1ns/1ps
module test_codec_digital_mode_control;
	import codec_mode_pkg::*;
	logic clk, sys_rst, fs_tick, zc_off, sck, bck, wr_en, rd_en, rd_valid;
	logic lflag, rflag, bco, boe, prev, fco, fprev;
	logic [2:0] oe; // Frame a, bit b, frame b drive enables
	logic [1:0] fcnt = 2'h0;
	logic [1:0] ratio, zdet, zc, busy, e;
	logic [7:0] att_l, att_r, rd_data, d, dl_l, dl_r, gl_l, gl_r, mn;
	ctrl_access_s access;
	dac_mode_s dac_mode;
	adc_mode_s adc_mode;
	int failures, comparisons, n, m;
	// Register port driver
	codec_host_model host (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .access(access),
		.rd_valid(rd_valid), .rd_data(rd_data));
	codec_digital_mode_control DUT (.clk(clk), .sys_rst(sys_rst), .ce(1'b1),
		.wr_en(wr_en), .rd_en(rd_en), .access(access), .rd_valid(rd_valid),
		.rd_data(rd_data), .fs_tick(fs_tick), .dac_sysclk_ratio(ratio),
		.dac_atten_left(att_l), .dac_atten_right(att_r), .dac_zero_detect(zdet),
		.adc_zero_cross(zc), .zc_detect_disable(zc_off), .sysclk_a(sck),
		.sysclk_b(1'b0), .bitclk_a(bck), .bitclk_b(~bck), .frameclk_a(bck),
		.frameclk_b(~bck), .dac_mode(dac_mode), .adc_mode(adc_mode),
		.dac_level_left(dl_l), .dac_level_right(dl_r), .adc_gain_level_left(gl_l),
		.adc_gain_level_right(gl_r), .adc_ramp_busy(busy), .left_silence_flag(lflag),
		.right_silence_flag(rflag), .adc_bitclk_out(bco), .adc_frameclk_out(fco),
		.bitclk_a_oe_n(boe), .frameclk_a_oe_n(oe[0]),
		.bitclk_b_oe_n(oe[1]), .frameclk_b_oe_n(oe[2]));
	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Sample tick every fourth cycle, system clock pin at a quarter rate
	always @(negedge clk) begin
		fcnt <= fcnt + 2'h1;
		fs_tick <= (fcnt == 2'h3);
		sck <= fcnt[1];
	end
	// Compare and count
	task automatic check(input string nm, input logic [7:0] s, input logic [7:0] x);
		comparisons++;
		if (s !== x) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, x, s);
		end
	endtask
	// Wait a number of sample ticks plus output lag
	task automatic ticks(input int k);
		repeat (k) @(posedge fs_tick);
		repeat (2) @(negedge clk);
	endtask
	// Verdict and end of run
	task automatic stop_test();
		if (failures == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Hang guard
	initial begin
		#300000;
		failures++;
		stop_test();
	end
	// Main sequence
	initial begin
		sys_rst = 1'b1;
		{zc_off, bck, ratio, zdet, zc} = 8'h00;
		att_l = 8'h38;
		att_r = 8'h37;
		failures = 0;
		comparisons = 0;
		repeat (6) @(negedge clk);
		sys_rst = 1'b0;
		// Reset values of all five registers
		for (int i = 0; i < 5; i++) begin
			host.read_reg(8'(ADDR_DAC_OUTPUT_CONTROL + i), d);
			check("reset reg", d, (i == 2 || i == 3) ? 8'hd7 : 8'h00);
		end
		// Unmapped address ignored
		host.write_reg(8'h43, 8'hff);
		host.read_reg(8'h43, d);
		check("unmapped", d, 8'h00);
		// Reserved bits, rate doubling and phase
		host.write_reg(ADDR_DAC_OUTPUT_CONTROL, 8'hff);
		host.read_reg(ADDR_DAC_OUTPUT_CONTROL, d);
		check("dac out ctl", d, 8'h47);
		for (int i = 0; i < 6; i++) begin
			if (i == 3) host.write_reg(ADDR_DAC_OUTPUT_CONTROL, 8'h00);
			ratio = 2'(i % 3);
			repeat (2) @(negedge clk);
			check("oversample", dac_mode.oversample_ratio, 8'h80 >> (i % 3 + (i > 2)));
			check("phase", {7'h0, dac_mode.phase_invert}, {7'h0, i < 3});
		end
		// Filter, de-emphasis and silence flags
		for (int i = 0; i < 4; i++) begin
			host.write_reg(ADDR_DAC_FILTER_FLAG_CONTROL,
				{i[0], 2'(i % 3), ~i[0], 2'b00, 2'(i)});
			repeat (2) @(negedge clk);
			check("filter", {4'h0, dac_mode.rolloff_sel, dac_mode.deemph_enable,
				dac_mode.deemph_rate_sel}, {4'h0, i[0], ~i[0], 2'(i % 3)});
			for (int z = 0; z < 4; z++) begin
				zdet = 2'(z);
				repeat (2) @(negedge clk);
				e = (i[0] ? {2{&zdet}} : zdet) ^ {2{i[1]}};
				check("flags", {6'h0, rflag, lflag}, {6'h0, e});
			end
		end
		// Port configuration fields
		for (int i = 0; i < 5; i++) begin
			host.write_reg(ADDR_ADC_PORT_CONFIG, {i[0], 3'(i), 2'b00, 2'(i % 4)});
			repeat (2) @(negedge clk);
			check("adc mode", {2'h0, adc_mode}, {2'h0, i[0], 3'(i), 2'(i % 4)});
		end
		// Master at 256 fs drives and divides the bit clock
		host.write_reg(ADDR_ADC_PORT_CONFIG, 8'h40);
		n = 0;
		m = 0;
		prev = bco;
		fprev = fco;
		repeat (1100) begin
			@(negedge clk);
			if (bco !== prev) n++;
			if (fco !== fprev) m++;
			prev = bco;
			fprev = fco;
		end
		check("master oe", {4'h0, oe, boe}, 8'h0c);
		check("bitclk rate", {7'h0, n > 132 && n < 143}, 8'h01);
		check("frameclk rate", {7'h0, m > 1 && m < 4}, 8'h01);
		// Slave relays the pins of the selected set
		host.write_reg(ADDR_ADC_PORT_CONFIG, 8'h00);
		bck = 1'b1;
		repeat (8) @(negedge clk);
		check("slave relay", {2'h0, oe, boe, bco, fco}, 8'h3f);
		host.write_reg(ADDR_ADC_PORT_CONFIG, 8'h80);
		repeat (8) @(negedge clk);
		check("slave set b", {2'h0, oe, boe, bco, fco}, 8'h3c);
		// Soft mute down and back up
		ticks(24);
		check("unmuted l", dl_l, 8'h38);
		host.write_reg(ADDR_DAC_OUTPUT_CONTROL, 8'h01);
		ticks(4);
		check("mute rate", {7'h0, dl_l == 8'h36}, 8'h00);
		ticks(24);
		check("muted l", dl_l, 8'h36);
		check("right kept", dl_r, 8'h37);
		host.write_reg(ADDR_DAC_OUTPUT_CONTROL, 8'h00);
		ticks(24);
		check("restored l", dl_l, 8'h38);
		// Gain ramp at zero crossings with buffered overwrite
		zc = 2'b11;
		host.write_reg(ADDR_ADC_LEFT_GAIN, 8'hd5);
		host.write_reg(ADDR_ADC_LEFT_GAIN, 8'hda);
		host.write_reg(ADDR_ADC_LEFT_GAIN, 8'hd8);
		check("busy", {7'h0, busy[0]}, 8'h01);
		mn = 8'hff;
		repeat (60) begin
			@(negedge clk);
			if (gl_l < mn) mn = gl_l;
			if (gl_l == 8'hda) mn = 8'h00;
		end
		check("ramp low", mn, 8'hd5);
		check("buffered", gl_l, 8'hd8);
		// No crossings: step waits for the timeout, then every tick
		zc = 2'b00;
		host.write_reg(ADDR_ADC_LEFT_GAIN, 8'hdb);
		ticks(500);
		check("zc wait", gl_l, 8'hd8);
		ticks(20);
		check("zc timeout", gl_l, 8'hdb);
		// Fixed interval stepping
		zc_off = 1'b1;
		host.write_reg(ADDR_ADC_RIGHT_GAIN, 8'hd9);
		ticks(4);
		check("fixed early", {7'h0, gl_r == 8'hd9}, 8'h00);
		ticks(16);
		check("fixed done", gl_r, 8'hd9);
		stop_test();
	end
endmodule
